// ===== div_if.sv
`include "fpu_params.svh"
`default_nettype none
interface div_if;
    logic start;
    logic [`MANT_W-1:0] num;
    logic [`MANT_W-1:0] den;
    logic done;
    logic [`QUO_W-1:0] quo;
    logic sticky;
    modport ctrl(output start, num, den, input done, quo, sticky);
    modport unit(input start, num, den, output done, quo, sticky);
endinterface : div_if
`default_nettype wire

// ===== fp_convert_and_divide_unit.sv
// Added by the designer: the register offsets and the address-and-strobe port.
`include "fpu_params.svh"
`default_nettype none
module fp_convert_and_divide_unit (
    input wire logic clk,
    input wire logic rst,
    input wire logic op_valid,
    input wire fpu_types_pkg::op_t op_code,
    input wire logic record_bit,
    input wire logic [4:0] target_freg,
    input wire logic [4:0] dividend_freg,
    input wire logic [4:0] source_b_freg,
    output logic op_ready,
    output logic op_done,
    output logic [3:0] cr1,
    input wire logic [7:0] addr,
    input wire logic [63:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [63:0] rdata,
    output logic irq
);
    fpu_types_pkg::state_t state;
    fpu_types_pkg::op_t op;
    fpu_types_pkg::unpacked_t ua;
    fpu_types_pkg::unpacked_t ub;
    logic rec;
    logic [4:0] tgt;
    logic [4:0] srcb;
    logic [4:0] fetch_addr;
    logic [63:0] opa;
    logic [63:0] opb;
    logic [63:0] rf_rd0;
    logic [63:0] rf_rd1;
    logic [31:0] fsc;
    logic [31:0] next_fsc;
    logic [1:0] irq_st;
    logic [1:0] irq_mask;
    logic [63:0] rdata_q;
    logic rd_fpr_q;
    logic dbl;
    logic [1:0] rn;
    logic [12:0] bias;
    logic [10:0] emax;
    logic [12:0] qexp;
    logic qsign;
    // Result staged for the finishing cycle
    logic [63:0] res_val;
    logic [31:0] res_set;
    logic [4:0] res_cls;
    logic res_fi;
    logic res_fr;
    logic res_upd;
    logic res_keep;
    logic [63:0] calc_val;
    logic [31:0] calc_set;
    logic [4:0] calc_cls;
    logic calc_upd;
    logic calc_keep;
    logic calc_div;
    logic [63:0] rnd_val;
    logic [31:0] rnd_set;
    logic [4:0] rnd_cls;
    logic rnd_fi;
    logic rnd_fr;
    logic bus_fpr_wr;
    logic fin_wr;
    logic [31:0] newset;

    div_if dv ();

    fp_divider u_div (
        .clk(clk),
        .rst(rst),
        .d(dv.unit)
    );

    fp_regfile u_rf (
        .clk(clk),
        .rst(rst),
        .we(fin_wr || bus_fpr_wr),
        .waddr(fin_wr ? tgt : addr[4:0]),
        .wdata(fin_wr ? res_val : wdata),
        .raddr0(addr[4:0]),
        .rdata0(rf_rd0),
        .raddr1(fetch_addr),
        .rdata1(rf_rd1)
    );

    function automatic logic [5:0] lead_zeros(input logic [52:0] m);
        logic [5:0] n;
        logic found;
        n = 6'h00;
        found = 1'b0;
        for (int i = 52; i >= 0; i--) begin
            if (m[i]) begin
                found = 1'b1;
            end else if (!found) begin
                n = n + 6'h01;
            end
        end
        return n;
    endfunction : lead_zeros

    function automatic fpu_types_pkg::unpacked_t unpack(input logic [63:0] v, input logic d);
        fpu_types_pkg::unpacked_t u;
        logic [10:0] ef;
        logic [51:0] fr;
        logic [10:0] em;
        logic [5:0] lz;
        ef = d ? v[62:52] : {3'h0, v[30:23]};
        fr = d ? v[51:0] : {v[22:0], 29'h0};
        em = d ? `EMAX_D : `EMAX_S;
        u.sign = d ? v[63] : v[31];
        u.nan = (ef == em) && (fr != 52'h0);
        u.inf = (ef == em) && (fr == 52'h0);
        u.snan = u.nan && !fr[51];
        u.zero = (ef == 11'h000) && (fr == 52'h0);
        lz = lead_zeros({ef != 11'h000, fr});
        u.mant = {ef != 11'h000, fr} << lz;
        u.exp = ((ef == 11'h000) ? 13'h0001 : {2'h0, ef}) - (d ? `BIAS_D : `BIAS_S)
            - {7'h00, lz};
        return u;
    endfunction : unpack

    // Builds a result in either format; single results sit in the low word
    function automatic logic [63:0] mk(input logic s, input logic [10:0] ef,
            input logic [51:0] fr, input logic d);
        return d ? {s, ef, fr} : {32'h0, s, ef[7:0], fr[51:29]};
    endfunction : mk

    assign dbl = (op != fpu_types_pkg::OP_DIV_SINGLE);
    assign rn = fsc[`FSC_RN];
    assign bias = dbl ? `BIAS_D : `BIAS_S;
    assign emax = dbl ? `EMAX_D : `EMAX_S;
    assign ua = unpack(opa, dbl);
    assign ub = unpack(opb, dbl);
    assign op_ready = (state == fpu_types_pkg::ST_IDLE);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= fpu_types_pkg::ST_IDLE;
            op <= fpu_types_pkg::OP_CONVERT;
            rec <= 1'b0;
            tgt <= 5'h00;
            srcb <= 5'h00;
            fetch_addr <= 5'h00;
            opa <= 64'h0;
            opb <= 64'h0;
        end else begin
            case (state)
                fpu_types_pkg::ST_IDLE: begin
                    if (op_valid) begin
                        op <= op_code;
                        rec <= record_bit;
                        tgt <= target_freg;
                        srcb <= source_b_freg;
                        fetch_addr <= (op_code == fpu_types_pkg::OP_CONVERT) ?
                            source_b_freg : dividend_freg;
                        state <= fpu_types_pkg::ST_FETCH_A;
                    end
                end
                fpu_types_pkg::ST_FETCH_A: begin
                    fetch_addr <= srcb;
                    state <= fpu_types_pkg::ST_FETCH_B;
                end
                fpu_types_pkg::ST_FETCH_B: begin
                    opa <= rf_rd1;
                    state <= fpu_types_pkg::ST_LATCH_B;
                end
                fpu_types_pkg::ST_LATCH_B: begin
                    opb <= rf_rd1;
                    state <= fpu_types_pkg::ST_CALC;
                end
                fpu_types_pkg::ST_CALC: begin
                    state <= calc_div ? fpu_types_pkg::ST_DIVIDE : fpu_types_pkg::ST_FINISH;
                end
                fpu_types_pkg::ST_DIVIDE: begin
                    if (dv.done) begin
                        state <= fpu_types_pkg::ST_FINISH;
                    end
                end
                default: begin
                    state <= fpu_types_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Convert path and divide special operands, resolved in one cycle
    always_comb begin
        logic [5:0] sh;
        logic [52:0] mag;
        logic [31:0] word;
        logic inv;
        sh = 6'h00;
        mag = 53'h0;
        word = 32'h0;
        inv = 1'b0;
        calc_val = 64'h0;
        calc_set = 32'h0;
        calc_cls = `CLS_QNAN;
        calc_upd = 1'b1;
        calc_keep = 1'b0;
        calc_div = 1'b0;
        if (op == fpu_types_pkg::OP_CONVERT) begin
            calc_upd = 1'b0;
            if (ub.nan) begin
                inv = 1'b1;
                word = `SAT_NEG;
                calc_set[`FSC_SNAN] = ub.snan;
            end else if ($signed(ub.exp) >= 13'sd31) begin
                if (ub.sign && ub.exp == 13'd31 && ub.mant[51:0] == 52'h0) begin
                    word = `SAT_NEG;
                end else begin
                    inv = 1'b1;
                    word = ub.sign ? `SAT_NEG : `SAT_POS;
                end
            end else if ($signed(ub.exp) < 13'sd0) begin
                calc_set[`FSC_XX] = !ub.zero;
            end else begin
                sh = 6'd52 - ub.exp[5:0];
                mag = ub.mant >> sh;
                calc_set[`FSC_XX] = ((ub.mant << (6'd53 - sh)) != 53'h0);
                word = ub.sign ? (32'h0 - mag[31:0]) : mag[31:0];
            end
            calc_set[`FSC_CVI] = inv;
            calc_keep = inv && fsc[`FSC_VE];
            // High word left as zero; callers must not rely on it
            calc_val = {32'h0, word};
        end else if (ua.nan || ub.nan) begin
            calc_set[`FSC_SNAN] = ua.snan || ub.snan;
            calc_keep = (ua.snan || ub.snan) && fsc[`FSC_VE];
            calc_val = ua.nan ? mk(ua.sign, emax, {1'b1, ua.mant[50:0]}, dbl) :
                mk(ub.sign, emax, {1'b1, ub.mant[50:0]}, dbl);
        end else if ((ua.inf && ub.inf) || (ua.zero && ub.zero)) begin
            calc_set[`FSC_IDI] = ua.inf;
            calc_set[`FSC_ZDZ] = ua.zero;
            calc_keep = fsc[`FSC_VE];
            calc_val = mk(1'b0, emax, {1'b1, 51'h0}, dbl);
        end else if (ua.inf || ub.zero) begin
            calc_set[`FSC_ZX] = ub.zero;
            calc_keep = ub.zero && fsc[`FSC_ZE];
            calc_cls = (ua.sign ^ ub.sign) ? `CLS_NINF : `CLS_PINF;
            calc_val = mk(ua.sign ^ ub.sign, emax, 52'h0, dbl);
        end else if (ua.zero || ub.inf) begin
            calc_cls = (ua.sign ^ ub.sign) ? `CLS_NZERO : `CLS_PZERO;
            calc_val = mk(ua.sign ^ ub.sign, 11'h000, 52'h0, dbl);
        end else begin
            calc_div = 1'b1;
        end
    end

    assign dv.start = (state == fpu_types_pkg::ST_CALC) && calc_div;
    assign dv.num = ua.mant;
    assign dv.den = ub.mant;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            qexp <= 13'h0;
            qsign <= 1'b0;
        end else if (dv.start) begin
            qexp <= ua.exp - ub.exp;
            qsign <= ua.sign ^ ub.sign;
        end
    end

    // Normalise, round and pack the quotient
    always_comb begin
        logic [55:0] q;
        logic [12:0] e;
        logic [12:0] be;
        logic [53:0] rk;
        logic g;
        logic s;
        logic inc;
        logic to_inf;
        q = dv.quo;
        e = qexp;
        be = 13'h0;
        rk = 54'h0;
        g = 1'b0;
        s = 1'b0;
        inc = 1'b0;
        to_inf = 1'b0;
        if (!q[55]) begin
            q = q << 1;
            e = e - 13'h1;
        end
        rk = dbl ? {1'b0, q[55:3]} : {30'h0, q[55:32]};
        g = dbl ? q[2] : q[31];
        s = dv.sticky || (dbl ? (q[1:0] != 2'h0) : (q[30:0] != 31'h0));
        case (rn)
            `RN_NEAR: inc = g && (s || rk[0]);
            `RN_POS: inc = !qsign && (g || s);
            `RN_NEG: inc = qsign && (g || s);
            default: inc = 1'b0;
        endcase
        rk = rk + {53'h0, inc};
        if (dbl ? rk[53] : rk[24]) begin
            rk = rk >> 1;
            e = e + 13'h1;
        end
        be = e + bias;
        to_inf = (rn == `RN_NEAR) || (rn == `RN_POS && !qsign) || (rn == `RN_NEG && qsign);
        rnd_set = 32'h0;
        rnd_fi = g || s;
        rnd_fr = inc;
        if ($signed(be) >= $signed({2'h0, emax})) begin
            rnd_set[`FSC_OX] = 1'b1;
            rnd_set[`FSC_XX] = 1'b1;
            rnd_fi = 1'b1;
            rnd_fr = 1'b0;
            rnd_val = to_inf ? mk(qsign, emax, 52'h0, dbl) :
                mk(qsign, emax - 11'h1, {52{1'b1}}, dbl);
            rnd_cls = to_inf ? (qsign ? `CLS_NINF : `CLS_PINF) :
                (qsign ? `CLS_NNORM : `CLS_PNORM);
        end else if ($signed(be) <= 13'sd0) begin
            // Tiny results flush to zero rather than forming a denormal
            rnd_set[`FSC_UX] = 1'b1;
            rnd_set[`FSC_XX] = 1'b1;
            rnd_fi = 1'b1;
            rnd_fr = 1'b0;
            rnd_val = mk(qsign, 11'h000, 52'h0, dbl);
            rnd_cls = qsign ? `CLS_NZERO : `CLS_PZERO;
        end else begin
            rnd_set[`FSC_XX] = g || s;
            rnd_val = mk(qsign, be[10:0], dbl ? rk[51:0] : {rk[22:0], 29'h0}, dbl);
            rnd_cls = qsign ? `CLS_NNORM : `CLS_PNORM;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            res_val <= 64'h0;
            res_set <= 32'h0;
            res_cls <= `CLS_PZERO;
            res_fi <= 1'b0;
            res_fr <= 1'b0;
            res_upd <= 1'b0;
            res_keep <= 1'b0;
        end else if (state == fpu_types_pkg::ST_CALC) begin
            res_val <= calc_val;
            res_set <= calc_set;
            res_cls <= calc_cls;
            res_fi <= 1'b0;
            res_fr <= 1'b0;
            res_upd <= calc_upd && !calc_keep;
            res_keep <= calc_keep;
        end else if (state == fpu_types_pkg::ST_DIVIDE && dv.done) begin
            res_val <= rnd_val;
            res_set <= rnd_set;
            res_cls <= rnd_cls;
            res_fi <= rnd_fi;
            res_fr <= rnd_fr;
            res_upd <= 1'b1;
            res_keep <= 1'b0;
        end
    end

    // A datapath write takes the port; a bus write to the register file in that cycle is lost
    assign fin_wr = (state == fpu_types_pkg::ST_FINISH) && !res_keep;
    assign bus_fpr_wr = wr && (addr[7:5] == `FPR_REGION) && !fin_wr;
    assign newset = res_set & ~fsc;

    // Hardware sets are applied after a software write, so a set is never lost
    always_comb begin
        next_fsc = (wr && addr == `REG_FSC) ? wdata[31:0] : fsc;
        if (state == fpu_types_pkg::ST_FINISH) begin
            next_fsc = next_fsc | res_set;
            if (res_upd) begin
                next_fsc[`FSC_RESULT_CLASS_FLAGS] = res_cls;
                next_fsc[`FSC_FI] = res_fi;
                next_fsc[`FSC_FR] = res_fr;
            end
            if (newset != 32'h0) begin
                next_fsc[`FSC_FX] = 1'b1;
            end
        end
        next_fsc[`FSC_VX] = next_fsc[`FSC_CVI] || next_fsc[`FSC_ZDZ] ||
            next_fsc[`FSC_IDI] || next_fsc[`FSC_SNAN];
        next_fsc[`FSC_FEX] = (next_fsc[`FSC_VX] && next_fsc[`FSC_VE]) ||
            (next_fsc[`FSC_OX] && next_fsc[`FSC_OE]) ||
            (next_fsc[`FSC_UX] && next_fsc[`FSC_UE]) ||
            (next_fsc[`FSC_ZX] && next_fsc[`FSC_ZE]) ||
            (next_fsc[`FSC_XX] && next_fsc[`FSC_XE]);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fsc <= `FSC_RESET;
        end else begin
            fsc <= next_fsc;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cr1 <= 4'h0;
        end else if (state == fpu_types_pkg::ST_FINISH && rec) begin
            cr1 <= {next_fsc[`FSC_FX], next_fsc[`FSC_FEX],
                next_fsc[`FSC_VX], next_fsc[`FSC_OX]};
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            op_done <= 1'b0;
        end else begin
            op_done <= (state == fpu_types_pkg::ST_FINISH);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_st <= 2'h0;
            irq_mask <= 2'h0;
        end else begin
            if (wr && addr == `REG_IRQ_MASK) begin
                irq_mask <= wdata[1:0];
            end
            irq_st <= ((rd && addr == `REG_IRQ_ST) ? 2'h0 : irq_st) |
                {(state == fpu_types_pkg::ST_FINISH) && (newset != 32'h0),
                 (state == fpu_types_pkg::ST_FINISH)};
        end
    end

    assign irq = |(irq_st & irq_mask);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_q <= 64'h0;
            rd_fpr_q <= 1'b0;
        end else begin
            rd_fpr_q <= rd && (addr[7:5] == `FPR_REGION);
            if (!rd) begin
                rdata_q <= 64'h0;
            end else if (addr == `REG_FSC) begin
                rdata_q <= {32'h0, fsc};
            end else if (addr == `REG_CR1) begin
                rdata_q <= {60'h0, cr1};
            end else if (addr == `REG_IRQ_ST) begin
                rdata_q <= {62'h0, irq_st};
            end else if (addr == `REG_IRQ_MASK) begin
                rdata_q <= {62'h0, irq_mask};
            end else begin
                rdata_q <= 64'h0;
            end
        end
    end

    // Both sources are registered, so the word still arrives one cycle after the strobe
    assign rdata = rd_fpr_q ? rf_rd0 : rdata_q;
endmodule : fp_convert_and_divide_unit
`default_nettype wire

// ===== fp_convert_and_divide_unit_properties.sv
`default_nettype none
module fp_cdu_checker (
    input wire logic clk,
    input wire logic rst,
    input wire logic op_valid,
    input wire fpu_types_pkg::op_t op_code,
    input wire logic record_bit,
    input wire logic [4:0] target_freg,
    input wire logic [4:0] dividend_freg,
    input wire logic [4:0] source_b_freg,
    input wire logic op_ready,
    input wire logic op_done,
    input wire logic [3:0] cr1,
    input wire logic [7:0] addr,
    input wire logic [63:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [63:0] rdata,
    input wire logic irq
);
    logic take;
    logic rec_q;
    assign take = op_valid && op_ready;
    // Record bit of the op in flight, so cr1 can be judged at its end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rec_q <= 1'b0;
        end else if (take) begin
            rec_q <= record_bit;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_convert_six_cycles: assert property (take && op_code == fpu_types_pkg::OP_CONVERT
        |-> ##6 op_done) else $error("convert late");
    a_divide_latency: assert property (take && op_code != fpu_types_pkg::OP_CONVERT
        |-> (##6 op_done) or (##63 op_done)) else $error("divide late");
    a_busy_after_take: assert property (take |=> !op_ready [*5])
        else $error("ready too soon");
    a_done_one_pulse: assert property (op_done |=> !op_done) else $error("done long");
    a_done_when_ready: assert property (op_done |-> op_ready)
        else $error("done while busy");
    a_cr1_at_done: assert property (!$stable(cr1) |-> op_done)
        else $error("cr1 moved");
    a_cr1_untouched: assert property (op_done && !rec_q |-> $stable(cr1))
        else $error("cr1 written");
    a_cr1_readback: assert property ($past(rd) && $past(addr) == 8'h01
        |-> rdata == {60'h0, $past(cr1)}) else $error("cr1 read");
endmodule : fp_cdu_checker
bind fp_convert_and_divide_unit fp_cdu_checker u_chk (.*);
`default_nettype wire

// ===== fp_divider.sv
`include "fpu_params.svh"
`default_nettype none
module fp_divider (
    input wire logic clk,
    input wire logic rst,
    div_if.unit d
);
    logic [`MANT_W:0] rem;
    logic [`QUO_W-1:0] acc;
    logic [5:0] cnt;
    logic run;
    logic done_q;

    // Restoring division, one quotient bit per cycle; the final remainder is kept and drives sticky
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rem <= '0;
            acc <= '0;
            cnt <= 6'h00;
            run <= 1'b0;
            done_q <= 1'b0;
        end else begin
            done_q <= run && (cnt == 6'h00);
            if (d.start) begin
                rem <= {1'b0, d.num};
                acc <= '0;
                cnt <= 6'(`QUO_W - 1);
                run <= 1'b1;
            end else if (run) begin
                if (rem >= {1'b0, d.den}) begin
                    rem <= (rem - {1'b0, d.den}) << 1;
                    acc <= {acc[`QUO_W-2:0], 1'b1};
                end else begin
                    rem <= rem << 1;
                    acc <= {acc[`QUO_W-2:0], 1'b0};
                end
                if (cnt == 6'h00) begin
                    run <= 1'b0;
                end
                cnt <= cnt - 6'h01;
            end
        end
    end

    assign d.done = done_q;
    assign d.quo = acc;
    assign d.sticky = (rem != '0);
endmodule : fp_divider
`default_nettype wire

// ===== fp_issue_model.sv
`default_nettype none
module fp_issue_model (
    input wire logic clk,
    input wire logic op_ready,
    input wire logic op_done,
    output logic op_valid,
    output fpu_types_pkg::op_t op_code,
    output logic record_bit,
    output logic [4:0] target_freg,
    output logic [4:0] dividend_freg,
    output logic [4:0] source_b_freg
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        op_valid = 1'b0;
        op_code = fpu_types_pkg::OP_CONVERT;
        record_bit = 1'b0;
        target_freg = 5'h00;
        dividend_freg = 5'h00;
        source_b_freg = 5'h00;
    end
    // Fields held with op_valid for exactly one cycle, only while idle
    task automatic issue(input fpu_types_pkg::op_t c, input logic r, input logic [4:0] t,
        input logic [4:0] a, input logic [4:0] b, output logic ok);
        ok = 1'b0;
        @(posedge clk);
        op_valid <= op_ready;
        op_code <= c;
        record_bit <= r;
        target_freg <= t;
        dividend_freg <= a;
        source_b_freg <= b;
        @(posedge clk);
        op_valid <= 1'b0;
        // Bounded wait covers the longest divide
        for (int n = 0; n < 80 && !ok; n++) begin
            @(posedge clk);
            #1 ok = (op_done === 1'b1);
        end
    endtask : issue
endmodule : fp_issue_model
`default_nettype wire

// ===== fp_regfile.sv
`include "fpu_params.svh"
`default_nettype none
module fp_regfile (
    input wire logic clk,
    input wire logic rst,
    input wire logic we,
    input wire logic [4:0] waddr,
    input wire logic [63:0] wdata,
    input wire logic [4:0] raddr0,
    output logic [63:0] rdata0,
    input wire logic [4:0] raddr1,
    output logic [63:0] rdata1
);
    logic [63:0] mem [0:`FPR_COUNT-1];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata0 <= 64'h0;
            rdata1 <= 64'h0;
        end else begin
            rdata0 <= mem[raddr0];
            rdata1 <= mem[raddr1];
        end
    end
endmodule : fp_regfile
`default_nettype wire

// ===== fpu_params.svh
`ifndef FPU_PARAMS_SVH
`define FPU_PARAMS_SVH
`define REG_FSC 8'h00
`define REG_CR1 8'h01
`define REG_IRQ_ST 8'h02
`define REG_IRQ_MASK 8'h03
`define FPR_REGION 3'h1
`define FPR_COUNT 32
`define FSC_RESET 32'h00000000
`define FSC_RN 1:0
`define FSC_XE 3
`define FSC_ZE 4
`define FSC_UE 5
`define FSC_OE 6
`define FSC_VE 7
`define FSC_RESULT_CLASS_FLAGS 16:12
`define FSC_FI 17
`define FSC_FR 18
`define FSC_CVI 19
`define FSC_ZDZ 20
`define FSC_IDI 21
`define FSC_SNAN 22
`define FSC_VX 23
`define FSC_XX 25
`define FSC_ZX 26
`define FSC_UX 27
`define FSC_OX 28
`define FSC_FEX 30
`define FSC_FX 31
`define RN_NEAR 2'h0
`define RN_ZERO 2'h1
`define RN_POS 2'h2
`define RN_NEG 2'h3
`define CLS_QNAN 5'h11
`define CLS_NINF 5'h09
`define CLS_NNORM 5'h08
`define CLS_NZERO 5'h12
`define CLS_PZERO 5'h02
`define CLS_PNORM 5'h04
`define CLS_PINF 5'h05
`define SAT_POS 32'h7FFFFFFF
`define SAT_NEG 32'h80000000
`define BIAS_D 13'h03FF
`define BIAS_S 13'h007F
`define EMAX_D 11'h7FF
`define EMAX_S 11'h0FF
`define MANT_W 53
`define QUO_W 56
`define IRQ_DONE 0
`define IRQ_EXC 1
`endif

// ===== fpu_types_pkg.sv
`default_nettype none
package fpu_types_pkg;
    typedef enum logic [1:0] {OP_CONVERT, OP_DIV_DOUBLE, OP_DIV_SINGLE} op_t;
    typedef enum logic [2:0] {
        ST_IDLE, ST_FETCH_A, ST_FETCH_B, ST_LATCH_B, ST_CALC, ST_DIVIDE, ST_FINISH
    } state_t;
    typedef struct packed {
        logic sign;
        logic [12:0] exp;
        logic [52:0] mant;
        logic zero;
        logic inf;
        logic nan;
        logic snan;
    } unpacked_t;
endpackage : fpu_types_pkg
`default_nettype wire

// ===== test_fp_convert_and_divide_unit.sv
`default_nettype none
module test_fp_convert_and_divide_unit;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [63:0] wdata = 64'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [63:0] rdata;
    logic op_valid, record_bit, op_ready, op_done, irq, ok;
    fpu_types_pkg::op_t op_code;
    logic [4:0] target_freg, dividend_freg, source_b_freg;
    logic [3:0] cr1;
    logic [63:0] v;
    int failures = 0;
    int n_checks = 0;
    int cyc = 0;
    always #2 clk = ~clk;
    fp_convert_and_divide_unit DUT (.*);
    fp_issue_model ISS (.*);
    task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic bus_wr(input logic [7:0] a, input logic [63:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : bus_wr
    task automatic rdc(input logic [7:0] a, input logic [63:0] exp, input string what);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
        check(what, exp, v);
    endtask : rdc
    task automatic run(input fpu_types_pkg::op_t c, input logic r, input logic [4:0] t,
        input logic [4:0] a, input logic [4:0] b);
        ISS.issue(c, r, t, a, b, ok);
        check("op_done", 64'h1, {63'h0, ok});
    endtask : run
    task automatic t_convert();
        rdc(8'h10, 64'h0, "unmapped");
        bus_wr(8'h21, 64'h400E000000000000);
        bus_wr(8'h22, 64'hC00E000000000000);
        run(fpu_types_pkg::OP_CONVERT, 1'b0, 5'h03, 5'h00, 5'h01);
        rdc(8'h23, 64'h3, "cvt pos");
        run(fpu_types_pkg::OP_CONVERT, 1'b0, 5'h04, 5'h00, 5'h02);
        rdc(8'h24, 64'hFFFFFFFD, "cvt neg");
    endtask : t_convert
    task automatic t_saturate();
        bus_wr(8'h00, 64'h0);
        bus_wr(8'h25, 64'h4270000000000000);
        bus_wr(8'h26, 64'hC270000000000000);
        run(fpu_types_pkg::OP_CONVERT, 1'b1, 5'h07, 5'h00, 5'h05);
        rdc(8'h27, 64'h7FFFFFFF, "sat pos");
        check("cr1", 64'hA, {60'h0, cr1});
        rdc(8'h01, 64'hA, "cr1 reg");
        rdc(8'h00, 64'h80880000, "status");
        check("cvi", 64'h1, {63'h0, v[19]});
        run(fpu_types_pkg::OP_CONVERT, 1'b0, 5'h08, 5'h00, 5'h06);
        rdc(8'h28, 64'h80000000, "sat neg");
        check("cr1 kept", 64'hA, {60'h0, cr1});
    endtask : t_saturate
    task automatic t_divide();
        bus_wr(8'h00, 64'h0);
        bus_wr(8'h29, 64'hC053400000000000);
        bus_wr(8'h2A, 64'h400C000000000000);
        run(fpu_types_pkg::OP_DIV_DOUBLE, 1'b1, 5'h0B, 5'h09, 5'h0A);
        rdc(8'h2B, 64'hC036000000000000, "div d");
        rdc(8'h00, 64'h8000, "div status");
        check("cr1 div", 64'h0, {60'h0, cr1});
        bus_wr(8'h2C, 64'h40C00000);
        bus_wr(8'h2D, 64'h40000000);
        run(fpu_types_pkg::OP_DIV_SINGLE, 1'b0, 5'h0E, 5'h0C, 5'h0D);
        rdc(8'h2E, 64'h40400000, "div s");
        bus_wr(8'h2F, 64'h3FF0000000000000);
        bus_wr(8'h30, 64'h0);
        run(fpu_types_pkg::OP_DIV_DOUBLE, 1'b0, 5'h11, 5'h0F, 5'h10);
        rdc(8'h31, 64'h7FF0000000000000, "div zero");
        rdc(8'h00, 64'h84005000, "zx status");
        check("zx result_class_flags", 64'h25, {58'h0, v[26], v[16:12]});
        bus_wr(8'h00, 64'h2);
        bus_wr(8'h33, 64'h3FF0000000000000);
        bus_wr(8'h34, 64'h4008000000000000);
        run(fpu_types_pkg::OP_DIV_DOUBLE, 1'b0, 5'h15, 5'h13, 5'h14);
        rdc(8'h35, 64'h3FD5555555555556, "div rn pos");
        rdc(8'h00, 64'h82064002, "rn status");
    endtask : t_divide
    task automatic t_irq();
        bus_wr(8'h03, 64'h0);
        rdc(8'h02, 64'h3, "irq clr");
        run(fpu_types_pkg::OP_CONVERT, 1'b0, 5'h12, 5'h00, 5'h01);
        rdc(8'h32, 64'h3, "cvt rz");
        check("irq masked", 64'h0, {63'h0, irq});
        bus_wr(8'h03, 64'h1);
        #1 check("irq on", 64'h1, {63'h0, irq});
        rdc(8'h02, 64'h1, "irq st");
        check("done bit", 64'h1, {63'h0, v[0]});
        check("irq off", 64'h0, {63'h0, irq});
    endtask : t_irq
    task automatic print_verdict();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : print_verdict
    // Ceiling well above the few hundred cycles the scenarios need
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            failures++;
            print_verdict();
        end
    end
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        t_convert();
        t_saturate();
        t_divide();
        t_irq();
        print_verdict();
    end
endmodule : test_fp_convert_and_divide_unit
`default_nettype wire
